// ===== bench/csc_clock_switch_checker.sv
// ****************************************************************
// port-level properties of the clock switch block
// ****************************************************************
module csc_clock_switch_checker #(
  parameter logic [2:0] RST_SOURCE  = csc_pkg::RST_SOURCE,
  parameter logic [3:0] RST_DIVIDER = csc_pkg::RST_DIVIDER
) (
  input wire logic        clk_i,       // clock
  input wire logic        rst_i,       // reset
  input wire logic        ce_i,        // enable
  input wire logic        wb_cyc_i,    // cycle
  input wire logic        wb_stb_i,    // strobe
  input wire logic        wb_we_i,     // write
  input wire logic [7:0]  wb_adr_i,    // address
  input wire logic [3:0]  wb_sel_i,    // lanes
  input wire logic [31:0] wb_dat_i,    // write data
  input wire logic [31:0] wb_dat_o,    // read data
  input wire logic        wb_ack_o,    // ack
  input wire logic [7:0]  osc_rdy_i,   // ready
  input wire logic        sleep_i,     // asleep
  input wire logic [2:0]  cur_src_o,   // source
  input wire logic [3:0]  cur_div_o,   // divider
  input wire logic [9:0]  cur_ratio_o, // ratio
  input wire logic        sosc_hp_o,   // power
  input wire logic        irq_o        // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       take;
  logic       rd_ctrl;
  logic       wr_ctrl;
  logic       wr_req;
  logic [6:0] req_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // accepted bus requests; the ack cycle is never taken again
  assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign rd_ctrl = take && !wb_we_i && wb_adr_i == csc_pkg::OFS_CTRL_STATUS;
  assign wr_ctrl = take && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == csc_pkg::OFS_CTRL_STATUS;
  assign wr_req  = take && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == csc_pkg::OFS_REQUEST
                   && wb_dat_i[3:0] <= 4'h9;

  // shadow of the request; reserved divider writes are dropped whole
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= {RST_SOURCE, RST_DIVIDER};
    end else if (wr_req) begin
      req_q <= wb_dat_i[6:0];
    end
  end

  // power-of-two ratio, zero for reserved codes
  function automatic logic [9:0] ratio_of(input logic [3:0] d);
    return (d > 4'h9) ? 10'h000 : (10'h001 << d);
  endfunction

  // flag read while the core has been asleep for a while
  sequence s_asleep_rd;
    sleep_i [*3] ##0 rd_ctrl;
  endsequence

  a_ratio_decode: assert property (
    ce_i |=> cur_ratio_o == ratio_of($past(cur_div_o)))
    else $error("current ratio does not match divider code");
  a_switch_target: assert property (
    ($changed(cur_src_o) || $changed(cur_div_o))
    |-> {cur_src_o, cur_div_o} == $past(req_q))
    else $error("clock changed to something other than the request");
  a_sosc_power: assert property (
    wr_ctrl |=> sosc_hp_o == $past(wb_dat_i[csc_pkg::SOSC_PWR_BIT]))
    else $error("power select output does not follow write");
  a_complete_flag: assert property (
    rd_ctrl |=> wb_dat_o[4] == ($past(req_q) == {$past(cur_src_o),
                                                 $past(cur_div_o)}))
    else $error("complete flag disagrees with request and current");
  a_asleep_flag: assert property (
    s_asleep_rd |=> wb_ack_o && !wb_dat_o[3])
    else $error("new source flag set while asleep");
  a_unused_zero: assert property (
    rd_ctrl |=> wb_dat_o[31:8] == 24'h000000 && !wb_dat_o[5]
                && wb_dat_o[2:0] == 3'h0)
    else $error("unimplemented control bits not zero");
  a_asleep_hold: assert property (
    $past(sleep_i) |-> $stable(cur_src_o) && $stable(cur_div_o))
    else $error("clock switched while asleep");
  a_ack_pulse: assert property (
    take ##1 ce_i |-> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack missing or longer than one cycle");
  a_ready_excl: assert property (
    rd_ctrl |=> !(wb_dat_o[3] && wb_dat_o[4]))
    else $error("new source flag set with no switch in progress");
endmodule

bind csc_clock_switch csc_clock_switch_checker #(
  .RST_SOURCE (RST_SOURCE),
  .RST_DIVIDER(RST_DIVIDER)
) i_chk (
  .clk_i      (clk_i),
  .rst_i      (rst_i),
  .ce_i       (ce_i),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_we_i    (wb_we_i),
  .wb_adr_i   (wb_adr_i),
  .wb_sel_i   (wb_sel_i),
  .wb_dat_i   (wb_dat_i),
  .wb_dat_o   (wb_dat_o),
  .wb_ack_o   (wb_ack_o),
  .osc_rdy_i  (osc_rdy_i),
  .sleep_i    (sleep_i),
  .cur_src_o  (cur_src_o),
  .cur_div_o  (cur_div_o),
  .cur_ratio_o(cur_ratio_o),
  .sosc_hp_o  (sosc_hp_o),
  .irq_o      (irq_o)
);

// ===== bench/tb_clock_switch_control.sv
module tb_clock_switch_control;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // stimulus, bus master and comparison
  // ****************************************************************
  localparam logic [7:0]  A_REQ = csc_pkg::OFS_REQUEST;
  localparam logic [7:0]  A_CTL = csc_pkg::OFS_CTRL_STATUS;
  localparam logic [7:0]  A_IRQ = csc_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0]  A_RAT = csc_pkg::OFS_RATIO;
  localparam logic [31:0] RST_SEL = {25'h0000000, csc_pkg::RST_SOURCE,
                                     csc_pkg::RST_DIVIDER};

  logic        clk_i, rst_i, ce_i, cyc, stb, we, sleep, ack, hp, irq;
  logic [7:0]  adr, rdy;
  logic [3:0]  sel, div;
  logic [2:0]  src;
  logic [9:0]  ratio;
  logic [31:0] wdat, rdat, rd;
  int          error_cnt, compares;

  csc_clock_switch i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_rdy_i(rdy),
    .sleep_i(sleep), .cur_src_o(src), .cur_div_o(div),
    .cur_ratio_o(ratio), .sosc_hp_o(hp), .irq_o(irq)
  );

  // 100 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle; the request stands until the ack edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000, 4'hF);
    chk(n, e, rd);
  endtask

  // bounded wait: the switch needs a few cycles of ready sync
  task automatic wait_cur(input logic [2:0] s, input logic [3:0] d);
    int n;
    n = 0;
    while ({src, div} !== {s, d} && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("cur_sel", {25'h0000000, s, d}, {25'h0000000, src, div});
  endtask

  task automatic t_reset;
    rc("request", A_REQ, RST_SEL);
    rc("current", csc_pkg::OFS_CURRENT, RST_SEL);
    rc("ctrl", A_CTL, 32'h00000010);
    rc("ratio", A_RAT, 32'h00010001);
    rc("mask", csc_pkg::OFS_IRQ_MASK, 32'h00000000);
    xfer(1'b1, A_CTL, 32'h000000FF, 4'h0);
    rc("ctrl_nosel", A_CTL, 32'h00000010);
    wr(8'h18, 32'hFFFFFFFF);
    rc("unmapped", 8'h18, 32'h00000000);
    wr(A_CTL, 32'hFFFFFFFF);
    rc("ctrl_ones", A_CTL, 32'h000000D0);
    wr(A_CTL, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_ratio;
    for (int d = 0; d < 16; d++) begin
      wr(A_REQ, 32'h00000060 | d);
      rc("req", A_REQ, 32'h00000060 | (d < 10 ? d : 9));
      rc("req_ratio", A_RAT,
         32'h00010000 | (32'h1 << (d < 10 ? d : 9)));
    end
    rc("ctrl_pend", A_CTL, 32'h00000000);
    wr(A_REQ, 32'h0000005A);
    rc("req_rsvd", A_REQ, 32'h00000069);
    wr(A_REQ, RST_SEL);
    rc("ctrl_back", A_CTL, 32'h00000010);
    $display("test ratio done");
  endtask

  task automatic t_switch;
    wr(csc_pkg::OFS_IRQ_MASK, 32'h00000002);
    wr(A_REQ, 32'h00000043);
    rc("ctrl_wait", A_CTL, 32'h00000000);
    // clock enable low: ready must not be seen, no switch may happen
    ce_i <= 1'b0;
    rdy  <= 8'h10;
    repeat (8) @(posedge clk_i);
    chk("frozen", RST_SEL, {25'h0000000, src, div});
    ce_i <= 1'b1;
    wait_cur(3'h4, 4'h3);
    repeat (2) @(posedge clk_i);
    chk("ratio_out", 32'h00000008, {22'h000000, ratio});
    chk("irq_up", 32'h00000001, {31'h00000000, irq});
    rc("ctrl_done", A_CTL, 32'h00000010);
    rc("irq_done", A_IRQ, 32'h00000002);
    repeat (3) @(posedge clk_i);
    chk("irq_clr", 32'h00000000, {31'h00000000, irq});
    $display("test switch done");
  endtask

  task automatic t_hold;
    wr(A_CTL, 32'h000000C0);
    chk("sosc_hi", 32'h00000001, {31'h00000000, hp});
    wr(A_REQ, 32'h00000051);
    rdy <= 8'h30;
    repeat (8) @(posedge clk_i);
    chk("held_sel", 32'h00000043, {25'h0000000, src, div});
    rc("ctrl_held", A_CTL, 32'h000000C8);
    chk("irq_masked", 32'h00000000, {31'h00000000, irq});
    rc("irq_held", A_IRQ, 32'h00000001);
    wr(A_CTL, 32'h00000040);
    wait_cur(3'h5, 4'h1);
    rc("ctrl_rel", A_CTL, 32'h00000050);
    rc("irq_rel", A_IRQ, 32'h00000002);
    $display("test hold done");
  endtask

  task automatic t_sleep;
    rdy   <= 8'h00;
    sleep <= 1'b1;
    wr(A_REQ, 32'h00000072);
    rdy <= 8'h80;
    repeat (8) @(posedge clk_i);
    chk("asleep_sel", 32'h00000051, {25'h0000000, src, div});
    rc("ctrl_asleep", A_CTL, 32'h00000040);
    sleep <= 1'b0;
    wait_cur(3'h7, 4'h2);
    rc("irq_wake", A_IRQ, 32'h00000002);
    wr(A_CTL, 32'h000000C0);
    sleep <= 1'b1;
    wr(A_REQ, 32'h00000060);
    rdy <= 8'hC0;
    repeat (4) @(posedge clk_i);
    sleep <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("wake_old", 32'h00000072, {25'h0000000, src, div});
    rc("ctrl_wake", A_CTL, 32'h000000C8);
    rc("irq_wake2", A_IRQ, 32'h00000001);
    wr(A_CTL, 32'h00000000);
    wait_cur(3'h6, 4'h0);
    chk("sosc_lo", 32'h00000000, {31'h00000000, hp});
    $display("test sleep done");
  endtask

  // ****************************************************************
  // sequence, watchdog and verdict
  // ****************************************************************
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; a hang stops well past that
  initial begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    compares  = 0;
    rst_i = 1'b1;
    ce_i  = 1'b1;
    {cyc, stb, we, sleep} = 4'h0;
    {adr, rdy, sel, wdat} = 52'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ratio();
    t_switch();
    t_hold();
    t_sleep();
    wrap_up();
  end
endmodule

// ===== inc/csc_pkg.sv
package csc_pkg;

  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int          WB_AW           = 8;
  localparam int          WB_DW           = 32;
  localparam int          WB_SW           = 4;
  localparam logic [7:0]  OFS_REQUEST     = 8'h00;
  localparam logic [7:0]  OFS_CURRENT     = 8'h04;
  localparam logic [7:0]  OFS_CTRL_STATUS = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h10;
  localparam logic [7:0]  OFS_RATIO       = 8'h14;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int SRC_W        = 3;
  localparam int DIV_W        = 4;
  localparam int RATIO_W      = 10;
  localparam int REG_W        = 8;
  localparam int SEL_LANE0    = 0;
  localparam int DIV_LSB      = 0;
  localparam int SRC_LSB      = 4;
  localparam int HOLD_BIT     = 7;
  localparam int SOSC_PWR_BIT = 6;
  localparam int COMPLETE_BIT = 4;
  localparam int NEW_RDY_BIT  = 3;
  localparam int RATIO_CUR_LSB = 16;
  localparam int N_SOURCES    = 8;
  localparam int IRQ_W        = 2;
  localparam int IRQ_HELD_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;

  // ****************************************************************
  // encodings and reset values
  // ****************************************************************
  localparam logic [DIV_W-1:0]   DIV_MAX_CODE   = 4'h9;
  localparam logic [RATIO_W-1:0] RATIO_ONE      = 10'h001;
  localparam logic [SRC_W-1:0]   RST_SOURCE     = 3'h6;
  localparam logic [DIV_W-1:0]   RST_DIVIDER    = 4'h0;
  localparam logic [REG_W-1:0]   RST_CTRL       = 8'h00;
  localparam logic [IRQ_W-1:0]   RST_IRQ        = 2'h0;

  // request or current clock selection
  typedef struct packed {
    logic [SRC_W-1:0] source;
    logic [DIV_W-1:0] divider;
  } csc_sel_t;

  // switch sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_HELD
  } csc_state_t;

endpackage

// ===== rtl/csc_clock_switch.sv
// Contract
// [R1] divider codes 0..9 give 1..512, rest reserved
// [R2] hold set: park ready switch, raise interrupt
// [R3] hold clear at ready rise: switch now
// [R4] power select bit picks secondary osc mode
// [R5] complete flag set when current equals request
// [R6] new-ready flag: switching and requested source ready
// [R7] new-ready flag low when idle or unready
// [R8] bits five and two..zero read zero
// [R9] wake with hold clear: new clock, interrupt
// [R10] wake with hold set: old clock, re-request
// [R11] request divider in bits 3..0, same encoding
// [R12] software releases hold; hardware clears it
module csc_clock_switch #(
  parameter logic [csc_pkg::SRC_W-1:0] RST_SOURCE  = csc_pkg::RST_SOURCE,
  parameter logic [csc_pkg::DIV_W-1:0] RST_DIVIDER = csc_pkg::RST_DIVIDER
) (
  input  wire logic                              clk_i,     // 100 MHz
  input  wire logic                              rst_i,     // sync, high
  input  wire logic                              ce_i,      // clock enable
  input  wire logic                              wb_cyc_i,  // bus cycle
  input  wire logic                              wb_stb_i,  // strobe
  input  wire logic                              wb_we_i,   // write
  input  wire logic [csc_pkg::WB_AW-1:0]         wb_adr_i,  // byte address
  input  wire logic [csc_pkg::WB_SW-1:0]         wb_sel_i,  // byte lanes
  input  wire logic [csc_pkg::WB_DW-1:0]         wb_dat_i,  // write data
  output logic      [csc_pkg::WB_DW-1:0]         wb_dat_o,  // read data
  output logic                                   wb_ack_o,  // acknowledge
  input  wire logic [csc_pkg::N_SOURCES-1:0]     osc_rdy_i, // per source
  input  wire logic                              sleep_i,   // core asleep
  output logic      [csc_pkg::SRC_W-1:0]         cur_src_o, // active source
  output logic      [csc_pkg::DIV_W-1:0]         cur_div_o, // active div
  output logic      [csc_pkg::RATIO_W-1:0]       cur_ratio_o, // active ratio
  output logic                                   sosc_hp_o, // sosc high pwr
  output logic                                   irq_o      // interrupt
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  csc_pkg::csc_sel_t           req_q;
  csc_pkg::csc_sel_t           cur_q;
  csc_pkg::csc_state_t         state_q;
  csc_pkg::csc_state_t         state_d;
  logic                        hold_q;
  logic                        sosc_pwr_q;
  logic                        nr_q;
  logic                        nr_d;
  logic                        sleep_q;
  logic                        wake;
  logic                        in_prog;
  logic                        nr_rise;
  logic                        do_switch;
  logic                        held_evt;
  logic [csc_pkg::N_SOURCES-1:0] rdy_s1_q;
  logic [csc_pkg::N_SOURCES-1:0] rdy_s2_q;
  logic [csc_pkg::IRQ_W-1:0]   irq_stat_q;
  logic [csc_pkg::IRQ_W-1:0]   irq_mask_q;
  logic                        irq_q;
  logic                        ack_q;
  logic [csc_pkg::WB_DW-1:0]   dat_q;
  logic                        bus_req;
  logic                        wr_lane0;
  logic                        rd_irq_stat;
  logic [csc_pkg::REG_W-1:0]   ctrl_rd;
  logic [csc_pkg::RATIO_W-1:0] req_ratio;
  logic [csc_pkg::RATIO_W-1:0] cur_ratio;
  logic                        req_div_rsvd;
  logic                        cur_div_rsvd;

  // ****************************************************************
  // bus strobes
  // ****************************************************************
  // one access per handshake: the ack cycle itself is not re-taken
  assign bus_req     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_lane0    = bus_req && wb_we_i && wb_sel_i[csc_pkg::SEL_LANE0];
  assign rd_irq_stat = bus_req && !wb_we_i
                       && (wb_adr_i == csc_pkg::OFS_IRQ_STATUS);

  // ****************************************************************
  // oscillator ready synchroniser
  // ****************************************************************
  // ready levels come from the oscillators' own clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_s1_q <= '0;
      rdy_s2_q <= '0;
    end else if (ce_i) begin
      rdy_s1_q <= osc_rdy_i;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // ****************************************************************
  // switch status
  // ****************************************************************
  // a switch is pending whenever request and active selection differ
  assign in_prog = (req_q != cur_q);                          // [R5]
  // ready only counts while switching and awake
  assign nr_d    = in_prog && rdy_s2_q[req_q.source]          // [R6]
                   && !sleep_i;                               // [R7]
  assign nr_rise = nr_d && !nr_q;
  assign wake    = sleep_q && !sleep_i;

  // registered new-ready flag, cleared on wake so it can rise again;
  // also cleared at the switch edge, else it would read 1 for a cycle
  // while request and current already agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nr_q    <= 1'b0;
      sleep_q <= 1'b0;
    end else if (ce_i) begin
      sleep_q <= sleep_i;
      if (wake || do_switch) begin
        nr_q <= 1'b0;                                         // [R10]
      end else begin
        nr_q <= nr_d;                                         // [R7]
      end
    end
  end

  // ****************************************************************
  // switch sequencer
  // ****************************************************************
  // decides when the active selection takes the requested one
  always_comb begin
    state_d   = state_q;
    do_switch = 1'b0;
    held_evt  = 1'b0;
    case (state_q)
      csc_pkg::ST_IDLE: begin
        if (in_prog) begin
          state_d = csc_pkg::ST_WAIT;
        end
      end
      csc_pkg::ST_WAIT: begin
        if (!in_prog) begin
          state_d = csc_pkg::ST_IDLE;
        end else if (wake && !hold_q) begin
          do_switch = 1'b1;                                   // [R9]
          state_d   = csc_pkg::ST_IDLE;
        end else if (wake) begin
          state_d = csc_pkg::ST_WAIT;                         // [R10]
        end else if (nr_rise && hold_q) begin
          held_evt = 1'b1;                                    // [R2]
          state_d  = csc_pkg::ST_HELD;
        end else if (nr_rise) begin
          do_switch = 1'b1;                                   // [R3]
          state_d   = csc_pkg::ST_IDLE;
        end
      end
      csc_pkg::ST_HELD: begin
        if (!in_prog) begin
          state_d = csc_pkg::ST_IDLE;
        end else if (wake && hold_q) begin
          state_d = csc_pkg::ST_WAIT;                         // [R10]
        end else if (wake || (!hold_q && nr_d)) begin
          do_switch = 1'b1;                                   // [R12]
          state_d   = csc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = csc_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= csc_pkg::ST_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // active selection follows the request only at a switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q.source  <= RST_SOURCE;
      cur_q.divider <= RST_DIVIDER;
    end else if (ce_i && do_switch) begin
      cur_q <= req_q;                                         // [R3]
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  // request; a reserved divider code drops the whole write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q.source  <= RST_SOURCE;
      req_q.divider <= RST_DIVIDER;
    end else if (ce_i && wr_lane0
                 && (wb_adr_i == csc_pkg::OFS_REQUEST)) begin
      if (wb_dat_i[csc_pkg::DIV_LSB +: csc_pkg::DIV_W]
          <= csc_pkg::DIV_MAX_CODE) begin                     // [R1]
        req_q.source  <= wb_dat_i[csc_pkg::SRC_LSB +: csc_pkg::SRC_W];
        req_q.divider <= wb_dat_i[csc_pkg::DIV_LSB +: csc_pkg::DIV_W];
      end                                                     // [R11]
    end
  end

  // hold and power select; hardware clears hold once switched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q     <= csc_pkg::RST_CTRL[csc_pkg::HOLD_BIT];
      sosc_pwr_q <= csc_pkg::RST_CTRL[csc_pkg::SOSC_PWR_BIT];
    end else if (ce_i) begin
      if (wr_lane0 && (wb_adr_i == csc_pkg::OFS_CTRL_STATUS)) begin
        hold_q     <= wb_dat_i[csc_pkg::HOLD_BIT];
        sosc_pwr_q <= wb_dat_i[csc_pkg::SOSC_PWR_BIT];        // [R4]
      end else if (do_switch) begin
        hold_q <= 1'b0;                                       // [R12]
      end
    end
  end

  // interrupt mask, same layout as the status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= csc_pkg::RST_IRQ;
    end else if (ce_i && wr_lane0
                 && (wb_adr_i == csc_pkg::OFS_IRQ_MASK)) begin
      irq_mask_q <= wb_dat_i[csc_pkg::IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // sticky events; a read clears them but a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= csc_pkg::RST_IRQ;
    end else if (ce_i) begin
      if (rd_irq_stat) begin
        irq_stat_q <= '0;
      end
      if (held_evt) begin
        irq_stat_q[csc_pkg::IRQ_HELD_BIT] <= 1'b1;            // [R2]
      end
      if (do_switch) begin
        irq_stat_q[csc_pkg::IRQ_DONE_BIT] <= 1'b1;            // [R9]
      end
    end
  end

  // level output, one cycle behind the status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************************************
  // divider decode
  // ****************************************************************
  csc_div_decode u_req_dec (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .code_i     (req_q.divider),
    .ratio_o    (req_ratio),
    .reserved_o (req_div_rsvd)
  );

  csc_div_decode u_cur_dec (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .code_i     (cur_q.divider),
    .ratio_o    (cur_ratio),
    .reserved_o (cur_div_rsvd)
  );

  // ****************************************************************
  // read path and acknowledge
  // ****************************************************************
  // unimplemented bits are constant zero, never stored
  assign ctrl_rd = {hold_q, sosc_pwr_q, 1'b0, !in_prog,       // [R8]
                    nr_q, 3'h0};                              // [R5]

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (ce_i && bus_req) begin
      dat_q <= '0;
      if (wb_we_i) begin
        dat_q <= '0;
      end else if (wb_adr_i == csc_pkg::OFS_REQUEST) begin
        dat_q[csc_pkg::REG_W-1:0] <= {1'b0, req_q};
      end else if (wb_adr_i == csc_pkg::OFS_CURRENT) begin
        dat_q[csc_pkg::REG_W-1:0] <= {1'b0, cur_q};           // [R11]
      end else if (wb_adr_i == csc_pkg::OFS_CTRL_STATUS) begin
        dat_q[csc_pkg::REG_W-1:0] <= ctrl_rd;                 // [R6]
      end else if (wb_adr_i == csc_pkg::OFS_IRQ_STATUS) begin
        dat_q[csc_pkg::IRQ_W-1:0] <= irq_stat_q;
      end else if (wb_adr_i == csc_pkg::OFS_IRQ_MASK) begin
        dat_q[csc_pkg::IRQ_W-1:0] <= irq_mask_q;
      end else if (wb_adr_i == csc_pkg::OFS_RATIO) begin
        dat_q[csc_pkg::RATIO_W-1:0] <= req_ratio;             // [R1]
        dat_q[csc_pkg::RATIO_CUR_LSB +: csc_pkg::RATIO_W] <= cur_ratio;
      end
    end
  end

  // every access, mapped or not, answers one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= bus_req;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_dat_o    = dat_q;
  assign wb_ack_o    = ack_q;
  assign cur_src_o   = cur_q.source;
  assign cur_div_o   = cur_q.divider;
  assign cur_ratio_o = cur_ratio;
  assign sosc_hp_o   = sosc_pwr_q;                            // [R4]
  assign irq_o       = irq_q;

endmodule

// ===== rtl/csc_div_decode.sv
// ******************************************************************
// divider code to division ratio, registered
// ******************************************************************
module csc_div_decode #(
  parameter int DIV_W   = csc_pkg::DIV_W,
  parameter int RATIO_W = csc_pkg::RATIO_W
) (
  input  wire logic               clk_i,      // system clock
  input  wire logic               rst_i,      // sync reset, high
  input  wire logic               ce_i,       // clock enable
  input  wire logic [DIV_W-1:0]   code_i,     // divider code
  output logic      [RATIO_W-1:0] ratio_o,    // ratio, 0 if reserved
  output logic                    reserved_o  // code is reserved
);

  logic [RATIO_W-1:0] ratio_q;
  logic               reserved_q;

  // power of two per step, reserved codes give zero ratio
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_q    <= csc_pkg::RATIO_ONE;
      reserved_q <= 1'b0;
    end else if (ce_i) begin
      if (code_i > csc_pkg::DIV_MAX_CODE) begin             // [R1]
        ratio_q    <= '0;
        reserved_q <= 1'b1;
      end else begin
        ratio_q    <= RATIO_W'(csc_pkg::RATIO_ONE << code_i); // [R1]
        reserved_q <= 1'b0;
      end
    end
  end

  assign ratio_o    = ratio_q;
  assign reserved_o = reserved_q;

endmodule
